//--- hdl/ttg_cmd.v
// What this block does
// RL1 - enlargement digit picks factor for later text
// RL2 - enlargement holds until screen switch or change
// RL3 - normal command clears inverse and flashing
// RL4 - set inverse leaves flashing alone
// RL5 - end inverse clears inverse only
// RL6 - set flashing leaves inverse alone
// RL7 - end flashing clears flashing only
// RL8 - inverse and flashing are independent flags
// RL9 - screen switch clears attributes
// RL10 - cursor command takes BCD x and y
// RL11 - cursor is bottom-left of enlarged character
// RL12 - string length hex 01 to 20h
// RL13 - string starts at cursor, wraps lines
// RL14 - every string element uses current attributes
// RL15 - polyline count hex 01 to 28h, BCD points
// RL16 - draw connected segments between successive points
// RL17 - circle takes BCD centre and radius
// RL18 - size digit selects normal or half height
// RL19 - clear command erases terminal drawing
// RL20 - escape, code, then collect parameters
// RL21 - bad or out-of-range parameters discard command; polyline segments already drawn before a bad point are kept
`timescale 1ns/1ps
`include "ttg_regs.vh"

module ttg_cmd (
  input  wire       clk_i,            // system clock, 100 MHz
  input  wire       sys_rst_i,        // synchronous reset, active high
  input  wire [7:0] rx_data_i,        // received byte
  input  wire       rx_valid_i,       // received byte strobe
  input  wire       screen_switch_i,  // displayed screen changes
  output reg  [2:0] enlarge_o,        // current enlargement code
  output reg        inverse_o,        // inverse attribute
  output reg        flash_o,          // flashing attribute
  output reg        half_size_o,      // half-size characters selected
  output wire [7:0] cursor_x_o,       // cursor x
  output wire [6:0] cursor_y_o,       // cursor y
  output reg        char_valid_o,     // draw one character
  output reg  [7:0] char_code_o,      // character code
  output reg  [7:0] char_x_o,         // character bottom-left x
  output reg  [6:0] char_y_o,         // character bottom-left y
  output reg  [2:0] char_enl_o,       // character enlargement
  output reg        char_inv_o,       // character inverse
  output reg        char_flash_o,     // character flashing
  output reg        char_half_o,      // character half size
  output reg        line_valid_o,     // draw one segment
  output reg  [7:0] line_x0_o,        // segment start x
  output reg  [6:0] line_y0_o,        // segment start y
  output reg  [7:0] line_x1_o,        // segment end x
  output reg  [6:0] line_y1_o,        // segment end y
  output reg        circle_valid_o,   // draw one circle
  output reg  [7:0] circle_x_o,       // circle centre x
  output reg  [6:0] circle_y_o,       // circle centre y
  output reg  [5:0] circle_r_o,       // circle radius
  output reg        clear_o,          // erase terminal drawing
  output reg        cmd_err_o         // command discarded
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_CODE = 2'h1;
  localparam [1:0] S_DIG  = 2'h2;
  localparam [1:0] S_STR  = 2'h3;

  reg  [1:0] st_q;
  reg  [7:0] code_q;
  reg  [1:0] gpos_q;
  reg  [1:0] fld_q;
  reg  [5:0] rem_q;
  reg        pfirst_q;
  reg  [7:0] tx_q;
  reg  [7:0] px_q;
  reg  [6:0] py_q;

  wire       dig_push;
  wire       hex_fld;
  wire [9:0] val;
  wire       bad;
  wire       grp_end;
  wire       x_ok;
  wire       y_ok;
  wire       pen_load;
  wire       pen_adv;
  wire [5:0] cw;
  wire [6:0] ch;

  // digits in the current field minus one
  function [1:0] last_pos;
    input [7:0] code;
    input [1:0] fld;
    begin
      if (code == `TTG_C_SIZE || code == `TTG_C_ENLARGE)
        last_pos = 2'h0;
      else if ((code == `TTG_C_STRING || code == `TTG_C_POLY) && fld == 2'h0)
        last_pos = 2'h1;
      else
        last_pos = 2'h2;
    end
  endfunction

  function [2:0] fac_w;
    input [2:0] enl;
    begin
      case (enl)
        3'h2, 3'h3: fac_w = 3'h2;
        3'h4:       fac_w = 3'h3;
        3'h5:       fac_w = 3'h4;
        default:    fac_w = 3'h1;
      endcase
    end
  endfunction

  function [2:0] fac_h;
    input [2:0] enl;
    begin
      case (enl)
        3'h1, 3'h3: fac_h = 3'h2;
        3'h4:       fac_h = 3'h3;
        3'h5:       fac_h = 3'h4;
        default:    fac_h = 3'h1;
      endcase
    end
  endfunction

  function in_range;
    input [9:0] v;
    input       b;
    input [9:0] lo;
    input [9:0] hi;
    begin
      in_range = !b && v >= lo && v <= hi;
    end
  endfunction

  assign dig_push = rx_valid_i && st_q == S_DIG;
  assign hex_fld  = (code_q == `TTG_C_STRING || code_q == `TTG_C_POLY) && fld_q == 2'h0;
  assign grp_end  = dig_push && gpos_q == last_pos(code_q, fld_q);
  assign x_ok     = in_range(val, bad, 10'h000, `TTG_X_MAX);
  assign y_ok     = in_range(val, bad, 10'h000, `TTG_Y_MAX);
  // cursor moves only once both coordinates are good
  assign pen_load = grp_end && code_q == `TTG_C_CURSOR && fld_q == 2'h1 && y_ok;  // [RL10] [RL21]
  assign pen_adv  = rx_valid_i && st_q == S_STR;
  assign cw       = {fac_w(enlarge_o), 3'h0};
  // half-size characters halve the base height before enlargement
  assign ch       = half_size_o ? {1'b0, fac_h(enlarge_o), 3'h0} : {fac_h(enlarge_o), 4'h0};

  ttg_digacc u_acc (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .push_i    (dig_push),
    .clr_i     (gpos_q == 2'h0),
    .hex_i     (hex_fld),
    .char_i    (rx_data_i),
    .nxt_o     (val),
    .bad_nxt_o (bad)
  );

  ttg_pen u_pen (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (pen_load),
    .x_i       (tx_q),
    .y_i       (val[6:0]),
    .adv_i     (pen_adv),
    .cw_i      (cw),
    .ch_i      (ch),
    .x_o       (cursor_x_o),
    .y_o       (cursor_y_o)
  );

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q           <= S_IDLE;
      code_q         <= 8'h00;
      gpos_q         <= 2'h0;
      fld_q          <= 2'h0;
      rem_q          <= 6'h00;
      pfirst_q       <= 1'b0;
      tx_q           <= 8'h00;
      px_q           <= 8'h00;
      py_q           <= 7'h00;
      enlarge_o      <= `TTG_ENL_RST;
      inverse_o      <= `TTG_INV_RST;
      flash_o        <= `TTG_FL_RST;
      half_size_o    <= `TTG_HALF_RST;
      char_valid_o   <= 1'b0;
      char_code_o    <= 8'h00;
      char_x_o       <= 8'h00;
      char_y_o       <= 7'h00;
      char_enl_o     <= 3'h0;
      char_inv_o     <= 1'b0;
      char_flash_o   <= 1'b0;
      char_half_o    <= 1'b0;
      line_valid_o   <= 1'b0;
      line_x0_o      <= 8'h00;
      line_y0_o      <= 7'h00;
      line_x1_o      <= 8'h00;
      line_y1_o      <= 7'h00;
      circle_valid_o <= 1'b0;
      circle_x_o     <= 8'h00;
      circle_y_o     <= 7'h00;
      circle_r_o     <= 6'h00;
      clear_o        <= 1'b0;
      cmd_err_o      <= 1'b0;
    end else begin
      char_valid_o   <= 1'b0;
      line_valid_o   <= 1'b0;
      circle_valid_o <= 1'b0;
      clear_o        <= 1'b0;
      cmd_err_o      <= 1'b0;
      if (rx_valid_i) begin
        case (st_q)
          S_IDLE: begin
            // plain bytes outside a command carry no meaning here
            if (rx_data_i == `TTG_ESC)
              st_q <= S_CODE;                                   // [RL20]
          end
          S_CODE: begin
            st_q   <= S_IDLE;
            gpos_q <= 2'h0;
            fld_q  <= 2'h0;
            case (rx_data_i)
              `TTG_C_NORMAL: begin
                inverse_o <= 1'b0;                              // [RL3]
                flash_o   <= 1'b0;                              // [RL3]
              end
              `TTG_C_INV_SET: inverse_o <= 1'b1;                // [RL4] [RL8]
              `TTG_C_INV_END: inverse_o <= 1'b0;                // [RL5] [RL8]
              `TTG_C_FL_SET:  flash_o   <= 1'b1;                // [RL6] [RL8]
              `TTG_C_FL_END:  flash_o   <= 1'b0;                // [RL7] [RL8]
              `TTG_C_CLEAR:   clear_o   <= 1'b1;                // [RL19]
              `TTG_C_SIZE, `TTG_C_ENLARGE, `TTG_C_CURSOR,
              `TTG_C_STRING, `TTG_C_POLY, `TTG_C_CIRCLE: begin
                code_q <= rx_data_i;                            // [RL20]
                st_q   <= S_DIG;
              end
              // a repeated escape restarts the sequence
              `TTG_ESC: st_q <= S_CODE;
              default: ;
            endcase
          end
          S_DIG: begin
            gpos_q <= gpos_q + 2'h1;
            if (grp_end) begin
              gpos_q <= 2'h0;
              fld_q  <= fld_q + 2'h1;
              st_q   <= S_IDLE;
              case (code_q)
                `TTG_C_ENLARGE: begin
                  if (in_range(val, bad, 10'h000, `TTG_ENL_MAX))
                    enlarge_o <= val[2:0];                      // [RL1] [RL2]
                  else
                    cmd_err_o <= 1'b1;                          // [RL21]
                end
                `TTG_C_SIZE: begin
                  if (in_range(val, bad, 10'h000, `TTG_SIZE_MAX))
                    half_size_o <= val[0];                      // [RL18]
                  else
                    cmd_err_o <= 1'b1;                          // [RL21]
                end
                `TTG_C_CURSOR: begin
                  if (fld_q == 2'h0 && x_ok) begin
                    tx_q <= val[7:0];                           // [RL10]
                    st_q <= S_DIG;
                  end else if (!(fld_q == 2'h1 && y_ok)) begin
                    cmd_err_o <= 1'b1;                          // [RL21]
                  end
                end
                `TTG_C_CIRCLE: begin
                  if (fld_q == 2'h0 && x_ok) begin
                    tx_q <= val[7:0];
                    st_q <= S_DIG;
                  end else if (fld_q == 2'h1 && y_ok) begin
                    py_q <= val[6:0];
                    st_q <= S_DIG;
                  end else if (fld_q == 2'h2 &&
                               in_range(val, bad, `TTG_R_MIN, `TTG_R_MAX)) begin
                    circle_valid_o <= 1'b1;                     // [RL17]
                    circle_x_o     <= tx_q;
                    circle_y_o     <= py_q;
                    circle_r_o     <= val[5:0];
                  end else begin
                    cmd_err_o <= 1'b1;                          // [RL21]
                  end
                end
                `TTG_C_STRING: begin
                  if (in_range(val, bad, `TTG_STR_MIN, `TTG_STR_MAX)) begin
                    rem_q <= val[5:0];                          // [RL12]
                    st_q  <= S_STR;
                  end else begin
                    cmd_err_o <= 1'b1;                          // [RL21]
                  end
                end
                `TTG_C_POLY: begin
                  if (fld_q == 2'h0) begin
                    if (in_range(val, bad, `TTG_POLY_MIN, `TTG_POLY_MAX)) begin
                      rem_q    <= val[5:0];                     // [RL15]
                      pfirst_q <= 1'b1;
                      st_q     <= S_DIG;
                    end else begin
                      cmd_err_o <= 1'b1;                        // [RL21]
                    end
                  end else if (fld_q == 2'h1) begin
                    if (x_ok) begin
                      tx_q <= val[7:0];                         // [RL15]
                      st_q <= S_DIG;
                    end else begin
                      cmd_err_o <= 1'b1;                        // [RL21]
                    end
                  end else if (!y_ok) begin
                    cmd_err_o <= 1'b1;                          // [RL21]
                  end else begin
                    // segments go out as points arrive; a later bad point stops the rest
                    fld_q <= 2'h1;
                    px_q  <= tx_q;
                    py_q  <= val[6:0];
                    if (pfirst_q) begin
                      pfirst_q <= 1'b0;
                      st_q     <= S_DIG;
                    end else begin
                      line_valid_o <= 1'b1;                     // [RL16]
                      line_x0_o    <= px_q;
                      line_y0_o    <= py_q;
                      line_x1_o    <= tx_q;
                      line_y1_o    <= val[6:0];
                      rem_q        <= rem_q - 6'h01;
                      if (rem_q != 6'h01)
                        st_q <= S_DIG;
                    end
                  end
                end
                default: ;
              endcase
            end
          end
          S_STR: begin
            // any byte, escape included, counts as string data here
            char_valid_o <= 1'b1;                               // [RL14]
            char_code_o  <= rx_data_i;
            char_x_o     <= cursor_x_o;                         // [RL11] [RL13]
            char_y_o     <= cursor_y_o;                         // [RL11] [RL13]
            char_enl_o   <= enlarge_o;                          // [RL1] [RL14]
            char_inv_o   <= inverse_o;                          // [RL8] [RL14]
            char_flash_o <= flash_o;                            // [RL8] [RL14]
            char_half_o  <= half_size_o;                        // [RL18]
            rem_q        <= rem_q - 6'h01;
            if (rem_q == 6'h01)
              st_q <= S_IDLE;
          end
          default: st_q <= S_IDLE;
        endcase
      end
      // screen switch wins over a command in the same cycle
      if (screen_switch_i) begin
        enlarge_o   <= `TTG_ENL_RST;                            // [RL2]
        inverse_o   <= `TTG_INV_RST;                            // [RL9]
        flash_o     <= `TTG_FL_RST;                             // [RL9]
        half_size_o <= `TTG_HALF_RST;                           // [RL18]
      end
    end
  end

endmodule // ttg_cmd

//--- pkg/ttg_regs.vh
`ifndef TTG_REGS_VH
`define TTG_REGS_VH

// command framing
`define TTG_ESC          8'h1B
`define TTG_C_NORMAL     8'h21
`define TTG_C_INV_SET    8'h22
`define TTG_C_INV_END    8'h23
`define TTG_C_FL_SET     8'h24
`define TTG_C_FL_END     8'h25
`define TTG_C_CLEAR      8'h26
`define TTG_C_SIZE       8'h29
`define TTG_C_ENLARGE    8'h2A
`define TTG_C_CURSOR     8'h2B
`define TTG_C_STRING     8'h34
`define TTG_C_POLY       8'h37
`define TTG_C_CIRCLE     8'h38

// parameter ranges
`define TTG_ENL_MAX      10'h005
`define TTG_SIZE_MAX     10'h001
`define TTG_X_MAX        10'h0FF
`define TTG_Y_MAX        10'h07F
`define TTG_R_MIN        10'h001
`define TTG_R_MAX        10'h03F
`define TTG_STR_MIN      10'h001
`define TTG_STR_MAX      10'h020
`define TTG_POLY_MIN     10'h001
`define TTG_POLY_MAX     10'h028

// reset values
`define TTG_ENL_RST      3'h0
`define TTG_HALF_RST     1'b0
`define TTG_INV_RST      1'b0
`define TTG_FL_RST       1'b0

// screen width and character geometry in dots
`define TTG_SCR_W        10'h100
`define TTG_CHAR_W_SH    3
`define TTG_CHAR_H_SH    4
`define TTG_HALF_H_SH    3

`endif

//--- hdl/ttg_digacc.v
`timescale 1ns/1ps
`include "ttg_regs.vh"

module ttg_digacc (
  input  wire       clk_i,      // system clock
  input  wire       sys_rst_i,  // synchronous reset, active high
  input  wire       push_i,     // digit character present
  input  wire       clr_i,      // start a new field with this digit
  input  wire       hex_i,      // 1: hexadecimal field, 0: BCD field
  input  wire [7:0] char_i,     // ascii character
  output wire [9:0] nxt_o,      // field value including this digit
  output wire       bad_nxt_o   // field holds a non-digit including this one
);

  reg  [9:0] val_q;
  reg        bad_q;
  wire [9:0] base;
  wire       ok;
  wire [3:0] dig;
  wire [9:0] scaled;

  function digit_ok;
    input [7:0] c;
    input       hex;
    begin
      digit_ok = (c >= 8'h30 && c <= 8'h39) ||
                 (hex && ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)));
    end
  endfunction

  function [3:0] digit_val;
    input [7:0] c;
    begin
      if (c <= 8'h39)
        digit_val = c[3:0];
      else
        digit_val = c[3:0] + 4'h9;
    end
  endfunction

  assign base      = clr_i ? 10'h000 : val_q;
  assign ok        = digit_ok(char_i, hex_i);
  assign dig       = ok ? digit_val(char_i) : 4'h0;
  // three BCD digits top out at 999, so ten bits never wrap
  assign scaled    = hex_i ? {base[5:0], 4'h0} : ({base[6:0], 3'h0} + {base[8:0], 1'b0});
  assign nxt_o     = scaled + {6'h00, dig};
  assign bad_nxt_o = (bad_q & ~clr_i) | ~ok;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      val_q <= 10'h000;
      bad_q <= 1'b0;
    end else if (push_i) begin
      val_q <= nxt_o;
      bad_q <= bad_nxt_o;
    end
  end

endmodule // ttg_digacc

//--- hdl/ttg_pen.v
`timescale 1ns/1ps
`include "ttg_regs.vh"

module ttg_pen (
  input  wire       clk_i,      // system clock
  input  wire       sys_rst_i,  // synchronous reset, active high
  input  wire       load_i,     // set cursor position
  input  wire [7:0] x_i,        // new cursor x
  input  wire [6:0] y_i,        // new cursor y
  input  wire       adv_i,      // one character placed
  input  wire [5:0] cw_i,       // character width in dots
  input  wire [6:0] ch_i,       // character height in dots
  output reg  [7:0] x_o,        // bottom-left x of next character
  output reg  [6:0] y_o         // bottom-left y of next character
);

  wire [9:0] nx;
  wire [9:0] nend;

  assign nx   = {2'h0, x_o} + {4'h0, cw_i};
  assign nend = nx + {4'h0, cw_i};

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      x_o <= 8'h00;
      y_o <= 7'h00;
    end else if (load_i) begin
      x_o <= x_i;
      y_o <= y_i;
    end else if (adv_i) begin
      // wrap before a character would cross the right edge; y wraps modulo the screen
      if (nend > `TTG_SCR_W) begin
        x_o <= 8'h00;
        y_o <= y_o + ch_i;                              // [RL13]
      end else begin
        x_o <= nx[7:0];
      end
    end
  end

endmodule // ttg_pen

//--- verification/ttg_host.sv
`timescale 1ns/1ps

module ttg_host (
  input  wire       clk_i,      // system clock
  output reg  [7:0] rx_data_o,  // byte to the interpreter
  output reg        rx_valid_o  // byte strobe
);
  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
  end

  task put(input [7:0] b);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o  = b;
  endtask

  // stale data is inverted so the interpreter cannot lean on a held value
  task idle;
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o  = ~rx_data_o;
  endtask

  // escape, code, then the parameter characters; slow leaves a gap before each parameter character
  task cmd(input [7:0] code, input string p, input bit slow);
    integer i;
    put(8'h1B);
    put(code);
    for (i = 0; i < p.len(); i++) begin
      if (slow) idle;
      put(p[i]);
    end
    idle;
  endtask
endmodule // ttg_host

//--- verification/ttg_cmd_asserts.sv
`timescale 1ns/1ps

module ttg_cmd_asserts (
  input wire       clk_i,           // clock
  input wire       sys_rst_i,       // reset
  input wire [7:0] rx_data_i,       // byte
  input wire       rx_valid_i,      // strobe
  input wire       screen_switch_i, // screen change
  input wire [2:0] enlarge_o,       // enlargement
  input wire       inverse_o,       // inverse
  input wire       flash_o,         // flashing
  input wire       half_size_o,     // half size
  input wire       char_valid_o,    // char strobe
  input wire [2:0] char_enl_o,      // char enlargement
  input wire       char_inv_o,      // char inverse
  input wire       char_flash_o,    // char flashing
  input wire       clear_o,         // erase
  input wire       cmd_err_o,       // discard
  input wire       circle_valid_o,  // circle strobe
  input wire [5:0] circle_r_o       // radius
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  reg  esc_q;
  always @(posedge clk_i) begin
    if (sys_rst_i) esc_q <= 1'b0;
    else esc_q <= rx_valid_i && (rx_data_i == 8'h1B);
  end
  // a switch in the same cycle wins over the command, so leave it out
  wire code_ok = esc_q && rx_valid_i && !screen_switch_i;

  normal_clears_a: assert property (
    code_ok && rx_data_i == 8'h21 |=> !inverse_o && !flash_o)
    else $error("normal display left an attribute set");
  inv_set_a: assert property (
    code_ok && rx_data_i == 8'h22 |=> inverse_o && $stable(flash_o))
    else $error("set inverse misbehaved");
  inv_end_a: assert property (
    code_ok && rx_data_i == 8'h23 |=> !inverse_o && $stable(flash_o))
    else $error("end inverse misbehaved");
  flash_set_a: assert property (
    code_ok && rx_data_i == 8'h24 |=> flash_o && $stable(inverse_o))
    else $error("set flashing misbehaved");
  flash_end_a: assert property (
    code_ok && rx_data_i == 8'h25 |=> !flash_o && $stable(inverse_o))
    else $error("end flashing misbehaved");
  switch_clr_a: assert property (
    screen_switch_i |=> enlarge_o == 3'h0 && !inverse_o && !flash_o && !half_size_o)
    else $error("screen switch left state behind");
  clear_pulse_a: assert property (
    code_ok && rx_data_i == 8'h26 |=> clear_o ##1 !clear_o)
    else $error("clear pulse missing or too long");
  err_pulse_a: assert property (cmd_err_o |=> !cmd_err_o)
    else $error("discard flag held too long");
  char_attr_a: assert property (
    char_valid_o |->
      char_inv_o == inverse_o && char_flash_o == flash_o && char_enl_o == enlarge_o)
    else $error("character drawn with stale attributes");
  circle_rad_a: assert property (circle_valid_o |-> circle_r_o != 6'h00)
    else $error("circle with zero radius");

  cover property (clear_o);
  cover property (char_valid_o ##1 char_valid_o);
  cover property (circle_valid_o);
  cover property (cmd_err_o);
endmodule // ttg_cmd_asserts

//--- verification/ttg_cmd_test.sv
`timescale 1ns/1ps

module ttg_cmd_test;
  logic        clk_i, sys_rst_i, screen_switch_i, rx_valid_i;
  logic [7:0]  rx_data_i, cursor_x_o, char_code_o, char_x_o, line_x0_o, line_x1_o, circle_x_o;
  logic [6:0]  cursor_y_o, char_y_o, line_y0_o, line_y1_o, circle_y_o;
  logic [2:0]  enlarge_o, char_enl_o;
  logic [5:0]  circle_r_o;
  logic        inverse_o, flash_o, half_size_o, char_valid_o, char_inv_o, char_flash_o;
  logic        char_half_o, line_valid_o, circle_valid_o, clear_o, cmd_err_o;
  integer      errors, cmp_count, n_clr, n_err, n_circ, e_err;
  logic [28:0] chq[$];
  logic [29:0] lnq[$];

  ttg_host i_ttg_host (.clk_i(clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));

  ttg_cmd i_ttg_cmd (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .screen_switch_i(screen_switch_i), .enlarge_o(enlarge_o), .inverse_o(inverse_o),
    .flash_o(flash_o), .half_size_o(half_size_o), .cursor_x_o(cursor_x_o),
    .cursor_y_o(cursor_y_o), .char_valid_o(char_valid_o), .char_code_o(char_code_o),
    .char_x_o(char_x_o), .char_y_o(char_y_o), .char_enl_o(char_enl_o),
    .char_inv_o(char_inv_o), .char_flash_o(char_flash_o), .char_half_o(char_half_o),
    .line_valid_o(line_valid_o), .line_x0_o(line_x0_o), .line_y0_o(line_y0_o),
    .line_x1_o(line_x1_o), .line_y1_o(line_y1_o), .circle_valid_o(circle_valid_o),
    .circle_x_o(circle_x_o), .circle_y_o(circle_y_o), .circle_r_o(circle_r_o),
    .clear_o(clear_o), .cmd_err_o(cmd_err_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // pulses last one cycle, so they are collected here rather than polled by the scenarios
  always @(posedge clk_i) begin
    if (char_valid_o === 1'b1)
      chq.push_back({char_code_o, char_x_o, char_y_o, char_enl_o, char_inv_o, char_flash_o,
                     char_half_o});
    if (line_valid_o === 1'b1) lnq.push_back({line_x0_o, line_y0_o, line_x1_o, line_y1_o});
    if (circle_valid_o === 1'b1) n_circ++;
    if (clear_o === 1'b1) n_clr++;
    if (cmd_err_o === 1'b1) n_err++;
  end

  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", n, exp, got);
    end
  endtask

  task run(input [7:0] code, input string p, input bit slow);
    i_ttg_host.cmd(code, p, slow);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task bad(input [7:0] code, input string p);
    run(code, p, 0);
    e_err++;
    chk("discards", n_err, e_err);
  endtask

  task t_attr;
    chk("reset state", {enlarge_o, inverse_o, flash_o, half_size_o}, 6'h00);
    run(8'h22, "", 0);
    chk("set inverse", {inverse_o, flash_o}, 2'b10);
    run(8'h24, "", 0);
    chk("set flashing", {inverse_o, flash_o}, 2'b11);
    run(8'h23, "", 0);
    chk("end inverse", {inverse_o, flash_o}, 2'b01);
    run(8'h22, "", 0);
    run(8'h25, "", 0);
    chk("end flashing", {inverse_o, flash_o}, 2'b10);
    run(8'h24, "", 0);
    run(8'h21, "", 0);
    chk("normal", {inverse_o, flash_o}, 2'b00);
    run(8'h1B, "\042", 0);
    chk("escape restart", inverse_o, 1'b1);
  endtask

  task t_mode;
    integer d;
    for (d = 0; d < 6; d++) begin
      run(8'h2A, $sformatf("%0d", d), 0);
      chk("enlarge", enlarge_o, d);
    end
    bad(8'h2A, "6");
    chk("enlarge kept", enlarge_o, 3'h5);
    run(8'h29, "1", 0);
    chk("half size", half_size_o, 1'b1);
    run(8'h22, "", 0);
    run(8'h24, "", 0);
    @(posedge clk_i);
    #1 screen_switch_i = 1'b1;
    @(posedge clk_i);
    #1 screen_switch_i = 1'b0;
    chk("switch clears", {enlarge_o, inverse_o, flash_o, half_size_o}, 6'h00);
  endtask

  task t_text;
    run(8'h2B, "255127", 0);
    chk("cursor", {cursor_x_o, cursor_y_o}, {8'hFF, 7'h7F});
    bad(8'h2B, "256000");
    bad(8'h2B, "1A0000");
    chk("cursor kept", cursor_x_o, 8'hFF);
    run(8'h2A, "3", 0);
    run(8'h22, "", 0);
    run(8'h2B, "240010", 0);
    run(8'h34, "02AB", 0);
    chk("char count", chq.size(), 2);
    chk("first char", chq[0], {8'h41, 8'd240, 7'd10, 3'd3, 3'b100});
    chk("wrapped char", chq[1], {8'h42, 8'd0, 7'd42, 3'd3, 3'b100});
    chk("cursor after", {cursor_x_o, cursor_y_o}, {8'd16, 7'd42});
    run(8'h34, "01\033", 0);
    chk("escape as data", chq[2][28:21], 8'h1B);
    run(8'h29, "1", 0);
    run(8'h2B, "240000", 0);
    run(8'h34, "01H", 0);
    chk("half char", chq[3], {8'h48, 8'd240, 7'd0, 3'd3, 3'b101});
    chk("half wrap", {cursor_x_o, cursor_y_o}, {8'd0, 7'd16});
    bad(8'h34, "21");
    bad(8'h34, "00");
    run(8'h21, "", 0);
  endtask

  task t_draw;
    run(8'h37, "02010020030040050060", 0);
    chk("segments", lnq.size(), 2);
    chk("segment 1", lnq[0], {8'd10, 7'd20, 8'd30, 7'd40});
    chk("segment 2", lnq[1], {8'd30, 7'd40, 8'd50, 7'd60});
    bad(8'h37, "29");
    run(8'h38, "100050063", 1);
    chk("circles", n_circ, 1);
    chk("circle", {circle_x_o, circle_y_o, circle_r_o}, {8'd100, 7'd50, 6'd63});
    bad(8'h38, "100050000");
    chk("no circle", n_circ, 1);
    run(8'h40, "", 0);
    chk("unknown code clear", n_clr, 0);
    chk("unknown code discard", n_err, e_err);
    run(8'h26, "", 0);
    chk("clear", n_clr, 1);
  endtask

  task tally_and_finish;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    n_clr = 0;
    n_err = 0;
    n_circ = 0;
    e_err = 0;
    sys_rst_i = 1'b1;
    screen_switch_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    t_attr;
    t_mode;
    t_text;
    t_draw;
    tally_and_finish;
  end
endmodule // ttg_cmd_test

bind ttg_cmd ttg_cmd_asserts i_ttg_cmd_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
  .screen_switch_i(screen_switch_i), .enlarge_o(enlarge_o), .inverse_o(inverse_o),
  .flash_o(flash_o), .half_size_o(half_size_o), .char_valid_o(char_valid_o),
  .char_enl_o(char_enl_o), .char_inv_o(char_inv_o), .char_flash_o(char_flash_o),
  .clear_o(clear_o), .cmd_err_o(cmd_err_o), .circle_valid_o(circle_valid_o),
  .circle_r_o(circle_r_o));
